// ===== osc_clock_select.sv
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`default_nettype none
module osc_clock_select
  import osc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Static configuration
  input  wire logic [2:0]  clock_mode_config,
  input  wire logic        two_speed_enable,
  input  wire logic        power_up_delay_timer_en,
  input  wire logic        watchdog_timer_en,
  input  wire logic        clock_fail_monitor_en,
  // Pins
  input  wire logic        osc_in_pin_i,
  output logic             osc_out_pin_o,
  output logic             osc_out_pin_oe_n,
  output logic             osc_in_gpio_free,
  output logic             osc_out_gpio_free,
  // Clock outputs
  output logic             system_clock_level,
  output logic             slow_time_base
);
  import osc_pkg::*;

  osc_if fast_if ();
  osc_if slow_if ();

  osc_source u_fast (
    .clk  (clk),
    .rst  (rst),
    .port (fast_if.osc)
  );

  osc_source u_slow (
    .clk  (clk),
    .rst  (rst),
    .port (slow_if.osc)
  );

  logic [2:0]          internal_freq_select;
  logic                sysclk_select;
  logic [TUNE_WIDTH-1:0] tune_value;
  logic                fast_osc_stable;
  logic                slow_osc_stable;
  logic                external_clock_active;
  switch_state_t       sw_state;
  logic [2:0]          cur_sel;
  logic [2:0]          pend_sel;
  logic                clk_hold;
  logic                cur_prev;
  logic                new_prev;
  logic                fast_prev;
  logic [POST_W-1:0]   post_cnt;
  logic                ext_meta;
  logic                ext_sync;
  logic                ext_prev;
  logic                int_clk;
  logic                int_prev;
  logic [DIV4_W-1:0]   div4_cnt;
  logic                internal_mode;
  logic                cur_level;
  logic                new_level;
  logic                switching;
  logic signed [33:0]  fast_target;

  function automatic logic uses_fast(input logic [2:0] code);
    uses_fast = (code != FREQ_31KHZ);
  endfunction

  // Postscaler: counter bit k is the fast clock divided by 2^(k+1)
  function automatic logic src_level(input logic [2:0] code);
    if (code == FREQ_31KHZ)
      src_level = slow_if.wave;
    else if (code == FREQ_8MHZ)
      src_level = fast_if.wave;
    else
      src_level = post_cnt[3'(FREQ_8MHZ - code - 3'h1)];
  endfunction

  // Pin input into the clock domain through two flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else
    begin
      ext_meta <= osc_in_pin_i;
      ext_sync <= ext_meta;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fast_prev <= 1'b0;
      post_cnt  <= '0;
    end
    else
    begin
      fast_prev <= fast_if.wave;
      if (fast_if.wave && !fast_prev)
        post_cnt <= post_cnt + 1'b1;
    end
  end

  assign switching = (sw_state != SW_IDLE);

  // Oscillators in use by a switch stay on until it completes
  assign fast_if.en = (uses_fast(internal_freq_select)
                       && (sysclk_select || two_speed_enable))
                      || (switching && (uses_fast(cur_sel) || uses_fast(pend_sel)));
  assign slow_if.en = (!uses_fast(internal_freq_select)
                       && (sysclk_select || two_speed_enable))
                      || power_up_delay_timer_en || watchdog_timer_en
                      || clock_fail_monitor_en
                      || (switching && (!uses_fast(cur_sel) || !uses_fast(pend_sel)));

  assign fast_target = 34'(FAST_INC)
                       + {{(34 - TUNE_WIDTH){tune_value[TUNE_WIDTH-1]}}, tune_value}
                       * $signed(TUNE_STEP);
  assign fast_if.inc = fast_target[31:0];
  assign slow_if.inc = SLOW_INC;

  assign slow_time_base = slow_if.wave;

  assign cur_level = src_level(cur_sel);
  assign new_level = src_level(pend_sel);

  // Glitch-free frequency switch. A source that is not running gives no
  // falling edge, so that wait is skipped rather than hanging.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sw_state        <= SW_IDLE;
      cur_sel         <= FREQ_SEL_RESET;
      pend_sel        <= FREQ_SEL_RESET;
      clk_hold        <= 1'b0;
      cur_prev        <= 1'b0;
      new_prev        <= 1'b0;
      fast_osc_stable <= 1'b0;
      slow_osc_stable <= 1'b0;
    end
    else
    begin
      cur_prev <= cur_level;
      new_prev <= new_level;
      case (sw_state)
        SW_IDLE:
        begin
          fast_osc_stable <= fast_if.stable;
          slow_osc_stable <= slow_if.stable;
          if (internal_freq_select != cur_sel)
          begin
            pend_sel <= internal_freq_select;
            sw_state <= SW_WARM;
          end
        end
        SW_WARM:
        begin
          // Postscaled fast codes share one running oscillator
          if (uses_fast(pend_sel) ? fast_if.stable : slow_if.stable)
            sw_state <= SW_FALL;
        end
        SW_FALL:
        begin
          if (!(uses_fast(cur_sel) ? fast_if.stable : slow_if.stable)
              || (cur_prev && !cur_level))
          begin
            clk_hold <= 1'b1;
            sw_state <= SW_RISE;
          end
        end
        SW_RISE:
        begin
          if (new_level && !new_prev)
          begin
            cur_sel         <= pend_sel;
            clk_hold        <= 1'b0;
            fast_osc_stable <= fast_if.stable;
            slow_osc_stable <= slow_if.stable;
            sw_state        <= SW_IDLE;
          end
        end
        default:
        begin
          clk_hold <= 1'b0;
          sw_state <= SW_IDLE;
        end
      endcase
    end
  end

  assign int_clk = clk_hold ? 1'b0 : cur_level;

  assign internal_mode = (clock_mode_config == MODE_INTERNAL_IO)
                         || (clock_mode_config == MODE_INTERNAL_DIVIDED_CLOCK_OUTPUT);

  assign external_clock_active = !(sysclk_select || internal_mode);

  // Automatic switchover is not modelled here and never touches the select
  // bit; software reads the active source from the status bit instead
  assign system_clock_level = sysclk_select ? int_clk
                              : (internal_mode ? int_clk : ext_sync);

  assign osc_in_gpio_free  = internal_mode;
  assign osc_out_gpio_free = !((clock_mode_config == MODE_RC_CLOCK)
                               || (clock_mode_config == MODE_INTERNAL_DIVIDED_CLOCK_OUTPUT));

  // Divide-by-four of the oscillator that feeds the output pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_prev         <= 1'b0;
      ext_prev         <= 1'b0;
      div4_cnt         <= '0;
      osc_out_pin_o    <= 1'b0;
      osc_out_pin_oe_n <= 1'b1;
    end
    else
    begin
      int_prev <= int_clk;
      ext_prev <= ext_sync;
      case (clock_mode_config)
        MODE_RC_CLOCK:
        begin
          osc_out_pin_oe_n <= 1'b0;
          if (ext_sync && !ext_prev)
            div4_cnt <= div4_cnt + 1'b1;
          osc_out_pin_o <= div4_cnt[DIV4_W-1];
        end
        MODE_INTERNAL_DIVIDED_CLOCK_OUTPUT:
        begin
          osc_out_pin_oe_n <= 1'b0;
          if (int_clk && !int_prev)
            div4_cnt <= div4_cnt + 1'b1;
          osc_out_pin_o <= div4_cnt[DIV4_W-1];
        end
        default:
        begin
          osc_out_pin_oe_n <= 1'b1;
          osc_out_pin_o    <= 1'b0;
          div4_cnt         <= '0;
        end
      endcase
    end
  end

  // Register slave: address and data may arrive in either order
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      internal_freq_select <= FREQ_SEL_RESET;
      sysclk_select        <= SYSCLK_SEL_RESET;
      tune_value           <= TUNE_RESET;
    end
    else if (do_write && w_strb[0])
    begin
      if (aw_addr == ADDR_OSC_CONTROL)
      begin
        internal_freq_select <= w_data[FREQ_SEL_LSB +: 3];
        sysclk_select        <= w_data[SYSCLK_SEL_BIT];
      end
      else if (aw_addr == ADDR_OSC_TUNING)
        tune_value <= w_data[TUNE_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == ADDR_OSC_CONTROL || aw_addr == ADDR_OSC_TUNING)
                      ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr == ADDR_OSC_CONTROL)
      begin
        s_axi_rdata[FREQ_SEL_LSB +: 3]  <= internal_freq_select;
        s_axi_rdata[EXT_ACTIVE_BIT]     <= external_clock_active;
        s_axi_rdata[FAST_STAB_BIT]      <= fast_osc_stable;
        s_axi_rdata[SLOW_STAB_BIT]      <= slow_osc_stable;
        s_axi_rdata[SYSCLK_SEL_BIT]     <= sysclk_select;
      end
      else if (s_axi_araddr == ADDR_OSC_TUNING)
        s_axi_rdata[TUNE_WIDTH-1:0] <= tune_value;
      else
        s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== osc_pkg.sv
`default_nettype none
package osc_pkg;
  // Bus map
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_OSC_TUNING  = 8'h04;
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  // Field layout of oscillator_control
  localparam int FREQ_SEL_LSB   = 4;
  localparam int EXT_ACTIVE_BIT = 3;
  localparam int FAST_STAB_BIT  = 2;
  localparam int SLOW_STAB_BIT  = 1;
  localparam int SYSCLK_SEL_BIT = 0;
  localparam int TUNE_WIDTH     = 5;

  // Reset values
  localparam logic [2:0] FREQ_SEL_RESET   = 3'h6;
  localparam logic       SYSCLK_SEL_RESET = 1'b0;
  localparam logic [4:0] TUNE_RESET       = 5'h00;

  // Frequency select codes
  localparam logic [2:0] FREQ_8MHZ  = 3'h7;
  localparam logic [2:0] FREQ_31KHZ = 3'h0;

  // Clock source configuration codes
  localparam logic [2:0] MODE_INTERNAL_IO     = 3'h4;
  localparam logic [2:0] MODE_INTERNAL_DIVIDED_CLOCK_OUTPUT = 3'h5;
  localparam logic [2:0] MODE_RC_IO           = 3'h6;
  localparam logic [2:0] MODE_RC_CLOCK        = 3'h7;

  // Oscillator models: phase increments per 10 ns clock, 2^32 full scale
  localparam logic [31:0] FAST_INC    = 32'h147ae148;
  localparam logic [31:0] SLOW_INC    = 32'h00145070;
  localparam logic [33:0] TUNE_STEP   = 34'h000051eb8;
  localparam logic [31:0] DRIFT_STEP  = 32'h00000400;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WARM_NS     = 2000;
  localparam int WARM_CYCLES   = (T_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_W        = 12;
  localparam int DIV4_W        = 2;
  localparam int POST_W        = 6;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WARM,
    SW_FALL,
    SW_RISE
  } switch_state_t;
endpackage
`default_nettype wire

// ===== osc_if.sv
`default_nettype none
interface osc_if;
  logic        en;
  logic [31:0] inc;
  logic        wave;
  logic        stable;

  modport ctrl (output en, output inc, input wave, input stable);
  modport osc  (input en, input inc, output wave, output stable);
endinterface
`default_nettype wire

// ===== osc_source.sv
`default_nettype none
module osc_source
  import osc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  osc_if.osc       port
);
  logic [31:0]       acc;
  logic [31:0]       cur_inc;
  logic [WARM_W-1:0] warm_cnt;

  // Start-up delay after enable; the wave only runs once warm
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      warm_cnt    <= '0;
      port.stable <= 1'b0;
    end
    else if (!port.en)
    begin
      warm_cnt    <= '0;
      port.stable <= 1'b0;
    end
    else if (!port.stable)
    begin
      warm_cnt    <= warm_cnt + 1'b1;
      port.stable <= (warm_cnt == WARM_W'(WARM_CYCLES - 1));
    end
  end

  // Frequency slews toward a new target instead of jumping, so retuning
  // never produces a short pulse; nothing reports when it arrives
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cur_inc <= '0;
    else if (!port.stable)
      cur_inc <= port.inc;
    else if (cur_inc + DRIFT_STEP < port.inc)
      cur_inc <= cur_inc + DRIFT_STEP;
    else if (cur_inc > port.inc + DRIFT_STEP)
      cur_inc <= cur_inc - DRIFT_STEP;
    else
      cur_inc <= port.inc;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acc <= '0;
    else if (!port.stable)
      acc <= '0;
    else
      acc <= acc + cur_inc;
  end

  assign port.wave = acc[31];
endmodule
`default_nettype wire

// ===== osc_clock_select_chk.sv
`default_nettype none
module osc_clock_select_chk
  import osc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  clock_mode_config,
  input wire logic        watchdog_timer_en,
  input wire logic        osc_out_pin_oe_n,
  input wire logic        osc_in_gpio_free,
  input wire logic        osc_out_gpio_free,
  input wire logic        slow_time_base
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles since the slow time base last moved; saturates so it never wraps
  logic [11:0] still_cnt;
  logic        last_base;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      still_cnt <= 12'h000;
      last_base <= 1'b0;
    end
    else
    begin
      last_base <= slow_time_base;
      if (!watchdog_timer_en || slow_time_base != last_base)
        still_cnt <= 12'h000;
      else if (still_cnt != 12'hfff)
        still_cnt <= still_cnt + 12'h001;
    end
  end

  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_AW_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != ADDR_OSC_CONTROL
    && s_axi_araddr != ADDR_OSC_TUNING |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_RC_IO_MODE_RELEASE: assert property (clock_mode_config == MODE_RC_IO
    |-> osc_out_pin_oe_n && osc_out_gpio_free && !osc_in_gpio_free) else $error("rc io pins wrong");
  AST_INTIO_FREE: assert property (clock_mode_config == MODE_INTERNAL_IO
    |-> osc_in_gpio_free && osc_out_gpio_free && osc_out_pin_oe_n) else $error("io pins not freed");
  AST_DIVIDED_CLOCK_OUTPUT_PINS: assert property (clock_mode_config == MODE_INTERNAL_DIVIDED_CLOCK_OUTPUT
    |-> osc_in_gpio_free && !osc_out_gpio_free) else $error("divided_clock_output pins wrong");
  AST_RC_PINS: assert property (clock_mode_config == MODE_RC_CLOCK
    |-> !osc_in_gpio_free && !osc_out_gpio_free) else $error("rc pins wrong");
  AST_SLOW_BASE: assert property (still_cnt < 12'h9c4)
    else $error("slow time base stalled");

  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($fell(osc_out_pin_oe_n));
endmodule

bind osc_clock_select osc_clock_select_chk osc_clock_select_chk_i (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .clock_mode_config(clock_mode_config), .watchdog_timer_en(watchdog_timer_en),
  .osc_out_pin_oe_n(osc_out_pin_oe_n), .osc_in_gpio_free(osc_in_gpio_free),
  .osc_out_gpio_free(osc_out_gpio_free), .slow_time_base(slow_time_base));
`default_nettype wire

// ===== rc_network_model.sv
`default_nettype none
module rc_network_model
#(
  parameter int HALF_NS = 50
)
(
  input  wire logic run,
  output logic      rc_level
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    rc_level = 1'b0;
    // Odd offset keeps the network out of phase with the system clock
    #3.3;
    forever
    begin
      #(HALF_NS);
      rc_level = run ? ~rc_level : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== internal_oscillator_clock_select_bench.sv
`default_nettype none
module internal_oscillator_clock_select_bench
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC_HALF_NS = 50;

  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, osc_in, osc_out, oe_n, in_free, out_free, sys_clk, slow_base;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  mode;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        two_speed;
  int          mismatches, samples_checked;

  osc_clock_select osc_clock_select_i (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .clock_mode_config(mode), .two_speed_enable(two_speed), .power_up_delay_timer_en(1'b0),
    .watchdog_timer_en(1'b1), .clock_fail_monitor_en(1'b0), .osc_in_pin_i(osc_in),
    .osc_out_pin_o(osc_out), .osc_out_pin_oe_n(oe_n), .osc_in_gpio_free(in_free),
    .osc_out_gpio_free(out_free), .system_clock_level(sys_clk), .slow_time_base(slow_base));

  rc_network_model #(.HALF_NS(RC_HALF_NS)) rc_network_model_i (.run(1'b1), .rc_level(osc_in));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Handshake seen at the falling edge is taken at the next rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
    logic       ta, tw, tb;
    logic [1:0] resp;
    int         n;
    tb = 1'b0;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 2000)
    begin
      n++;
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    check("bvalid_seen", {31'h0, tb}, 32'h1);
    check("bresp", {30'h0, resp}, {30'h0, exp_resp});
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 2000)
    begin
      n++;
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    check("rvalid_seen", {31'h0, done}, 32'h1);
  endtask

  // Status bits settle after oscillator warm-up, so poll with a bound
  task automatic poll_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    axi_read(a, d, r);
    while (d !== exp && n < 3000)
    begin
      n++;
      axi_read(a, d, r);
    end
    check(name, d, exp);
  endtask

  task automatic check_rate(input string name, input int exp, input logic use_sys);
    logic p;
    int   t;
    t = 0;
    @(negedge clk);
    p = use_sys ? sys_clk : osc_out;
    repeat (2000)
    begin
      @(negedge clk);
      if ((use_sys ? sys_clk : osc_out) !== p) t++;
      p = use_sys ? sys_clk : osc_out;
    end
    check(name, {31'h0, t >= exp - exp / 20 - 1 && t <= exp + exp / 20 + 1}, 32'h1);
  endtask

  task automatic reg_basics();
    logic [31:0] d;
    logic [1:0]  r;
    poll_reg("control_reset", ADDR_OSC_CONTROL, 32'h6a);
    poll_reg("tune_reset", ADDR_OSC_TUNING, 32'h0);
    axi_write(ADDR_OSC_CONTROL, 32'hffffffee, 4'hf, RESP_OKAY);
    poll_reg("status_read_only", ADDR_OSC_CONTROL, 32'h6a);
    axi_write(ADDR_OSC_TUNING, 32'h0f, 4'hf, RESP_OKAY);
    poll_reg("tune_max", ADDR_OSC_TUNING, 32'h0f);
    axi_write(ADDR_OSC_TUNING, 32'hfffffff0, 4'hf, RESP_OKAY);
    poll_reg("tune_min", ADDR_OSC_TUNING, 32'h10);
    axi_write(ADDR_OSC_TUNING, 32'h05, 4'he, RESP_OKAY);
    poll_reg("tune_strobe", ADDR_OSC_TUNING, 32'h10);
    poll_reg("tune_no_flag", ADDR_OSC_CONTROL, 32'h6a);
    axi_write(8'h08, 32'hff, 4'hf, RESP_SLVERR);
    axi_read(8'h08, d, r);
    check("unmapped_data", d, 32'h0);
    check("unmapped_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  task automatic freq_walk();
    for (int c = 7; c >= 0; c--)
    begin
      axi_write(ADDR_OSC_CONTROL, {25'h0, c[2:0], 4'h1}, 4'h1, RESP_OKAY);
      poll_reg("freq_code", ADDR_OSC_CONTROL, {25'h0, c[2:0], 1'b0, c != 0, 2'b11});
    end
  endtask

  task automatic divided_clock_output_run();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(ADDR_OSC_CONTROL, d, r);
    check("reset_select", d & 32'h71, 32'h60);
    axi_write(ADDR_OSC_CONTROL, 32'h71, 4'h1, RESP_OKAY);
    poll_reg("fast_running", ADDR_OSC_CONTROL, 32'h77);
    check_rate("divided_clock_output_8m", 80 >> (7 - 7), 1'b0);
    axi_write(ADDR_OSC_CONTROL, 32'h61, 4'h1, RESP_OKAY);
    // A switch waits for an old falling and a new rising edge first
    repeat (100) @(posedge clk);
    check_rate("divided_clock_output_4m", 80 >> (7 - 6), 1'b0);
    check_rate("sysclk_4m", 160, 1'b1);
    check("divided_clock_output_drive", {31'h0, oe_n}, 32'h0);
  endtask

  // Two-speed start-up alone turns the fast oscillator on, select bit stays 0
  task automatic two_speed_run();
    @(posedge clk);
    rst <= 1'b1;
    two_speed <= 1'b1;
    do_reset(3'h0);
    poll_reg("two_speed_fast", ADDR_OSC_CONTROL, 32'h6e);
  endtask

  initial
  begin
    rst = 1'b1;
    mode = 3'h0;
    two_speed = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    do_reset(3'h0);
    reg_basics();
    freq_walk();
    do_reset(MODE_INTERNAL_DIVIDED_CLOCK_OUTPUT);
    divided_clock_output_run();
    do_reset(MODE_INTERNAL_IO);
    check_rate("intio_quiet", 0, 1'b0);
    check("intio_release", {31'h0, oe_n}, 32'h1);
    do_reset(MODE_RC_IO);
    check_rate("rc_io_mode_quiet", 0, 1'b0);
    check("rc_io_mode_release", {31'h0, oe_n}, 32'h1);
    do_reset(MODE_RC_CLOCK);
    check_rate("rc_div4", 20000 / (4 * RC_HALF_NS), 1'b0);
    check("rc_drive", {31'h0, oe_n}, 32'h0);
    check_rate("sysclk_rc", 20000 / RC_HALF_NS, 1'b1);
    two_speed_run();
    complete_run();
  end

  initial
  begin
    #600000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
